// ===== rtl/tcie_core.sv
// Instruction execute core with register file, I/O bit space and flags.
// Assumes an AXI4-Lite master on aclk; instructions arrive by bus writes.
//
// Summary of operation
// - Add with carry, six flags, one cycle.
// - Word add constant to pair, two cycles.
// - Word subtract constant from pair, two cycles.
// - Subtract with carry registers, six flags, one.
// - Subtract constant from register, six flags, one.
// - AND/OR constant, only Z N V.
// - Clear/set bits by mask, Z N V.
// - Test ANDs register with itself, Z N V.
// - Jump via pointer pair, two cycles.
// - Call via pointer, save return, three cycles.
// - Compare registers, skip next when equal.
// - Compare with constant, flags only, one cycle.
// - Skip on register bit clear or set.
// - Skip on I/O bit clear or set.
// - Branch when selected flag set, offset plus one.
// - Signed branch when N xor V zero.
// - Unsigned branch when carry is zero.
// - Branch on interrupt enable set or clear.
// - I/O bit set/clear, two cycles, flags kept.
// - Rotate right through carry, one cycle.
// - Bit store and load via transfer flag.
// - Clear or set overflow flag alone.
// - Bit access only for I/O up to 0x1F.
// - I/O bit ops touch only addressed bit.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module tcie_core (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel.
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data channel.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address channel.
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data channel.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	tcie_pkg::tcie_state_s q;
	tcie_pkg::tcie_state_s n;

	// Updates C, Z, N, V and S together; S always follows N xor V.
	function automatic logic [7:0] set_flags(input logic [7:0] f, input logic z,
		input logic ng, input logic v, input logic c);
		logic [7:0] r;
		r = f;
		r[tcie_pkg::FL_Z] = z;
		r[tcie_pkg::FL_N] = ng;
		r[tcie_pkg::FL_V] = v;
		r[tcie_pkg::FL_C] = c;
		r[tcie_pkg::FL_S] = ng ^ v;
		return r;
	endfunction

	// Eight-bit subtract with borrow; returns half borrow, overflow, borrow, result.
	function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [7:0] r;
		logic h;
		logic v;
		logic c;
		r = a - b - {7'h00, ci};
		h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		return {h, v, c, r};
	endfunction

	// Flags of a logic result: V cleared; carry, half carry and sign are all kept.
	function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] r);
		logic [7:0] o;
		o = set_flags(f, r == 8'h00, r[7], 1'b0, f[tcie_pkg::FL_C]);
		o[tcie_pkg::FL_S] = f[tcie_pkg::FL_S];
		return o;
	endfunction

	// Next state: bus slave, instruction execution and busy countdown.
	always_comb begin
		logic [31:0] iw;
		logic [4:0] op;
		logic [4:0] di;
		logic [4:0] ri;
		logic [4:0] pl;
		logic [4:0] ph;
		logic [7:0] kk;
		logic [2:0] bs;
		logic [5:0] ioa;
		logic [7:0] rd;
		logic [7:0] rr;
		logic [7:0] res;
		logic [8:0] sum9;
		logic [10:0] sr;
		logic [15:0] pw;
		logic [15:0] pwr;
		logic [15:0] pcn;
		logic [1:0] cyc;
		logic [11:0] ra;
		logic [11:0] wa;
		logic skp;
		logic brn;
		logic cond;
		logic bitv;
		iw = q.wdata;
		op = iw[tcie_pkg::F_OP +: 5];
		di = iw[tcie_pkg::F_D +: 5];
		ri = iw[tcie_pkg::F_R +: 5];
		pl = {di[4:1], 1'b0};
		ph = {di[4:1], 1'b1};
		kk = iw[tcie_pkg::F_K +: 8];
		bs = iw[tcie_pkg::F_B +: 3];
		ioa = kk[5:0];
		rd = q.gpr[di];
		rr = q.gpr[ri];
		res = 8'h00;
		sum9 = 9'h000;
		sr = 11'h000;
		pw = {q.gpr[ph], q.gpr[pl]};
		pwr = 16'h0000;
		pcn = q.pc + tcie_pkg::STEP_ONE;
		cyc = tcie_pkg::CYC1;
		ra = {s_axi_araddr[11:2], 2'b00};
		wa = {q.awaddr[11:2], 2'b00};
		skp = 1'b0;
		brn = 1'b0;
		cond = 1'b0;
		bitv = (ioa <= tcie_pkg::IO_BIT_MAX) ? q.io[ioa[4:0]][bs] : 1'b0;
		n = q;

		// Busy countdown of a multi-cycle instruction.
		if (q.st == tcie_pkg::ST_EXEC) begin
			n.left = q.left - 2'h1;
			if (q.left == 2'h1) begin
				n.st = tcie_pkg::ST_IDLE;
			end
		end

		// Read channel: one read at a time, answered the cycle after it is taken.
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (q.arready && s_axi_arvalid) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = tcie_pkg::RESP_OKAY;
			n.rdata = 32'h00000000;
			if (ra == tcie_pkg::OFS_INSTR) begin
				n.rdata = q.instr;
			end else if (ra == tcie_pkg::OFS_STATUS) begin
				n.rdata = {16'h0000, q.flags, 5'h00, q.last_cyc, q.st == tcie_pkg::ST_EXEC};
			end else if (ra == tcie_pkg::OFS_FLAGS) begin
				n.rdata = {24'h000000, q.flags};
			end else if (ra == tcie_pkg::OFS_PC) begin
				n.rdata = {16'h0000, q.pc};
			end else if (ra == tcie_pkg::OFS_RET) begin
				n.rdata = {16'h0000, q.ret};
			end else if (ra[11:7] == tcie_pkg::OFS_GPR[11:7]) begin
				n.rdata = {24'h000000, q.gpr[ra[6:2]]};
			end else if (ra[11:7] == tcie_pkg::OFS_IO[11:7]) begin
				n.rdata = {24'h000000, q.io[ra[6:2]]};
			end else begin
				n.rresp = tcie_pkg::RESP_SLVERR;
			end
		end else if (!q.arready && !q.rvalid) begin
			n.arready = 1'b1;
		end

		// Write address and data are caught independently.
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (q.awready && s_axi_awvalid) begin
			n.aw_have = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (q.wready && s_axi_wvalid) begin
			n.w_have = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end

		// A write completes only while no instruction is still running.
		if (q.aw_have && q.w_have && !q.bvalid && q.st == tcie_pkg::ST_IDLE) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = tcie_pkg::RESP_OKAY;
			if (wa == tcie_pkg::OFS_INSTR) begin
				// Execute the written instruction; results commit at this edge.
				case (op)
					tcie_pkg::OP_ADC: begin
						sum9 = {1'b0, rd} + {1'b0, rr} + {8'h00, q.flags[tcie_pkg::FL_C]};
						res = sum9[7:0];
						n.gpr[di] = res;
						n.flags = set_flags(q.flags, res == 8'h00, res[7],
							(rd[7] & rr[7] & ~res[7]) | (~rd[7] & ~rr[7] & res[7]), sum9[8]);
						n.flags[tcie_pkg::FL_H] = (rd[3] & rr[3]) | (rr[3] & ~res[3])
							| (~res[3] & rd[3]);
					end
					tcie_pkg::OP_WADD: begin
						pwr = pw + {10'h000, kk[5:0]};
						n.gpr[pl] = pwr[7:0];
						n.gpr[ph] = pwr[15:8];
						n.flags = set_flags(q.flags, pwr == 16'h0000, pwr[15],
							~pw[15] & pwr[15], ~pwr[15] & pw[15]);
						cyc = tcie_pkg::CYC2;
					end
					tcie_pkg::OP_WSUB: begin
						pwr = pw - {10'h000, kk[5:0]};
						n.gpr[pl] = pwr[7:0];
						n.gpr[ph] = pwr[15:8];
						n.flags = set_flags(q.flags, pwr == 16'h0000, pwr[15],
							pw[15] & ~pwr[15], pwr[15] & ~pw[15]);
						cyc = tcie_pkg::CYC2;
					end
					tcie_pkg::OP_SUBC: begin
						sr = sub8(rd, rr, q.flags[tcie_pkg::FL_C]);
						n.gpr[di] = sr[7:0];
						n.flags = set_flags(q.flags, (sr[7:0] == 8'h00) & q.flags[tcie_pkg::FL_Z],
							sr[7], sr[9], sr[8]);
						n.flags[tcie_pkg::FL_H] = sr[10];
					end
					tcie_pkg::OP_SUBK: begin
						sr = sub8(rd, kk, 1'b0);
						n.gpr[di] = sr[7:0];
						n.flags = set_flags(q.flags, sr[7:0] == 8'h00, sr[7], sr[9], sr[8]);
						n.flags[tcie_pkg::FL_H] = sr[10];
					end
					tcie_pkg::OP_ANDK, tcie_pkg::OP_CLRM: begin
						res = rd & ((op == tcie_pkg::OP_CLRM) ? tcie_pkg::MASK_ALL - kk : kk);
						n.gpr[di] = res;
						n.flags = logic_flags(q.flags, res);
					end
					tcie_pkg::OP_ORK, tcie_pkg::OP_SETM: begin
						res = rd | kk;
						n.gpr[di] = res;
						n.flags = logic_flags(q.flags, res);
					end
					tcie_pkg::OP_TEST: begin
						n.flags = logic_flags(q.flags, rd & rd);
					end
					tcie_pkg::OP_JPTR: begin
						pcn = {q.gpr[tcie_pkg::PTR_HI], q.gpr[tcie_pkg::PTR_LO]};
						cyc = tcie_pkg::CYC2;
					end
					tcie_pkg::OP_CPTR: begin
						n.ret = q.pc + tcie_pkg::STEP_ONE;
						pcn = {q.gpr[tcie_pkg::PTR_HI], q.gpr[tcie_pkg::PTR_LO]};
						cyc = tcie_pkg::CYC3;
					end
					tcie_pkg::OP_CSEQ: begin
						skp = 1'b1;
						cond = rd == rr;
					end
					tcie_pkg::OP_CMPK: begin
						sr = sub8(rd, kk, 1'b0);
						n.flags = set_flags(q.flags, sr[7:0] == 8'h00, sr[7], sr[9], sr[8]);
						n.flags[tcie_pkg::FL_H] = sr[10];
					end
					tcie_pkg::OP_SRBC, tcie_pkg::OP_SRBS: begin
						skp = 1'b1;
						cond = rd[bs] ~^ op[0];
					end
					tcie_pkg::OP_SIBC, tcie_pkg::OP_SIBS: begin
						skp = 1'b1;
						cond = bitv ~^ op[0];
					end
					tcie_pkg::OP_BFS: begin
						brn = 1'b1;
						cond = q.flags[bs];
					end
					tcie_pkg::OP_BSGE: begin
						brn = 1'b1;
						cond = ~(q.flags[tcie_pkg::FL_N] ^ q.flags[tcie_pkg::FL_V]);
					end
					tcie_pkg::OP_BUGE: begin
						brn = 1'b1;
						cond = ~q.flags[tcie_pkg::FL_C];
					end
					tcie_pkg::OP_BIE, tcie_pkg::OP_BID: begin
						brn = 1'b1;
						cond = q.flags[tcie_pkg::FL_I] ~^ op[0];
					end
					tcie_pkg::OP_SETIO, tcie_pkg::OP_CLRIO: begin
						if (ioa <= tcie_pkg::IO_BIT_MAX) begin
							n.io[ioa[4:0]][bs] = op == tcie_pkg::OP_SETIO;
						end
						cyc = tcie_pkg::CYC2;
					end
					tcie_pkg::OP_RORC: begin
						res = {q.flags[tcie_pkg::FL_C], rd[7:1]};
						n.gpr[di] = res;
						n.flags = set_flags(q.flags, res == 8'h00, res[7], res[7] ^ rd[0],
							rd[0]);
					end
					tcie_pkg::OP_TSTORE: begin
						n.flags[tcie_pkg::FL_T] = rd[bs];
					end
					tcie_pkg::OP_TLOAD: begin
						n.gpr[di][bs] = q.flags[tcie_pkg::FL_T];
					end
					tcie_pkg::OP_CLROV, tcie_pkg::OP_SETOV: begin
						n.flags[tcie_pkg::FL_V] = op == tcie_pkg::OP_SETOV;
					end
					default: begin
						cyc = tcie_pkg::CYC1;
					end
				endcase
				// Skips step over one or two words; taken branches cost one more cycle.
				if (skp && cond) begin
					pcn = q.pc + (iw[tcie_pkg::F_TWO] ? tcie_pkg::SKIP_TWO : tcie_pkg::SKIP_ONE);
					cyc = iw[tcie_pkg::F_TWO] ? tcie_pkg::CYC3 : tcie_pkg::CYC2;
				end
				if (brn && cond) begin
					pcn = q.pc + {{9{kk[6]}}, kk[6:0]} + tcie_pkg::STEP_ONE;
					cyc = tcie_pkg::CYC2;
				end
				n.pc = pcn;
				n.instr = iw;
				n.last_cyc = cyc;
				n.left = cyc - tcie_pkg::CYC1;
				if (cyc != tcie_pkg::CYC1) begin
					n.st = tcie_pkg::ST_EXEC;
				end
			end else if (wa == tcie_pkg::OFS_FLAGS) begin
				if (q.wstrb[0]) begin
					n.flags = q.wdata[7:0];
				end
			end else if (wa == tcie_pkg::OFS_PC) begin
				if (q.wstrb[0]) begin
					n.pc[7:0] = q.wdata[7:0];
				end
				if (q.wstrb[1]) begin
					n.pc[15:8] = q.wdata[15:8];
				end
			end else if (wa == tcie_pkg::OFS_STATUS || wa == tcie_pkg::OFS_RET) begin
				n.bresp = tcie_pkg::RESP_OKAY;
			end else if (wa[11:7] == tcie_pkg::OFS_GPR[11:7]) begin
				if (q.wstrb[0]) begin
					n.gpr[wa[6:2]] = q.wdata[7:0];
				end
			end else if (wa[11:7] == tcie_pkg::OFS_IO[11:7]) begin
				if (q.wstrb[0]) begin
					n.io[wa[6:2]] = q.wdata[7:0];
				end
			end else begin
				n.bresp = tcie_pkg::RESP_SLVERR;
			end
		end

		// Ready is offered again once the held item has been used.
		n.awready = !n.aw_have;
		n.wready = !n.w_have;
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.flags <= tcie_pkg::RST_FLAGS;
			q.pc <= tcie_pkg::RST_PC;
		end else begin
			q <= n;
		end
	end

	// Bus outputs straight from the state register.
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;

endmodule

// ===== rtl/tcie_pkg.sv
// Constants and types shared by the instruction execute core.
// Assumes a single clock domain and an AXI4-Lite master reaching the map.
package tcie_pkg;
	// Byte offsets of the register map.
	localparam logic [11:0] OFS_INSTR = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_FLAGS = 12'h008;
	localparam logic [11:0] OFS_PC = 12'h00c;
	localparam logic [11:0] OFS_RET = 12'h010;
	localparam logic [11:0] OFS_GPR = 12'h100;
	localparam logic [11:0] OFS_IO = 12'h200;
	// Field positions inside an instruction word.
	localparam int F_OP = 27;
	localparam int F_D = 22;
	localparam int F_R = 17;
	localparam int F_TWO = 16;
	localparam int F_K = 8;
	localparam int F_B = 0;
	// Bit positions inside the status flags register.
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam int FL_I = 7;
	// Values after reset.
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [15:0] RST_PC = 16'h0000;
	// Cycle counts and program counter steps.
	localparam logic [1:0] CYC1 = 2'h1;
	localparam logic [1:0] CYC2 = 2'h2;
	localparam logic [1:0] CYC3 = 2'h3;
	localparam logic [15:0] STEP_ONE = 16'h0001;
	localparam logic [15:0] SKIP_ONE = 16'h0002;
	localparam logic [15:0] SKIP_TWO = 16'h0003;
	// Operand limits and fixed register indices.
	localparam logic [5:0] IO_BIT_MAX = 6'h1f;
	localparam logic [7:0] MASK_ALL = 8'hff;
	localparam logic [4:0] PTR_LO = 5'h1e;
	localparam logic [4:0] PTR_HI = 5'h1f;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Operation codes.
	localparam logic [4:0] OP_ADC = 5'h00;
	localparam logic [4:0] OP_WADD = 5'h01;
	localparam logic [4:0] OP_WSUB = 5'h02;
	localparam logic [4:0] OP_SUBC = 5'h03;
	localparam logic [4:0] OP_SUBK = 5'h04;
	localparam logic [4:0] OP_ANDK = 5'h05;
	localparam logic [4:0] OP_ORK = 5'h06;
	localparam logic [4:0] OP_SETM = 5'h07;
	localparam logic [4:0] OP_CLRM = 5'h08;
	localparam logic [4:0] OP_TEST = 5'h09;
	localparam logic [4:0] OP_JPTR = 5'h0a;
	localparam logic [4:0] OP_CPTR = 5'h0b;
	localparam logic [4:0] OP_CSEQ = 5'h0c;
	localparam logic [4:0] OP_CMPK = 5'h0d;
	localparam logic [4:0] OP_SRBC = 5'h0e;
	localparam logic [4:0] OP_SRBS = 5'h0f;
	localparam logic [4:0] OP_SIBC = 5'h10;
	localparam logic [4:0] OP_SIBS = 5'h11;
	localparam logic [4:0] OP_BFS = 5'h12;
	localparam logic [4:0] OP_BSGE = 5'h13;
	localparam logic [4:0] OP_BUGE = 5'h14;
	localparam logic [4:0] OP_BIE = 5'h15;
	localparam logic [4:0] OP_BID = 5'h16;
	localparam logic [4:0] OP_SETIO = 5'h17;
	localparam logic [4:0] OP_CLRIO = 5'h18;
	localparam logic [4:0] OP_RORC = 5'h19;
	localparam logic [4:0] OP_TSTORE = 5'h1a;
	localparam logic [4:0] OP_TLOAD = 5'h1b;
	localparam logic [4:0] OP_CLROV = 5'h1c;
	localparam logic [4:0] OP_SETOV = 5'h1d;
	// Execution state.
	typedef enum logic [0:0] {ST_IDLE, ST_EXEC} tcie_st_e;
	// Whole state of the core.
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic [11:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0][7:0] gpr;
		logic [31:0][7:0] io;
		logic [7:0] flags;
		logic [15:0] pc;
		logic [15:0] ret;
		logic [31:0] instr;
		logic [1:0] left;
		logic [1:0] last_cyc;
		tcie_st_e st;
	} tcie_state_s;
endpackage

// ===== tb/tcie_prog_rom.sv
// Program store model that hands instruction words to the bench.
// Assumes the bench loads it once after reset and then only reads it.
`timescale 1ns/100ps
module tcie_prog_rom (
	// Clock.
	input wire logic aclk,
	// Load and read side.
	input wire logic load,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	logic [31:0] mem [256];

	// Words are stored on a load edge and read back without delay.
	always @(posedge aclk) begin
		if (load) begin
			mem[addr] <= wdata;
		end
	end
	assign rdata = mem[addr];
endmodule

// ===== tb/tcie_core_sva.sv
// Checker for the register bus handshakes of the execute core.
// Assumes it is bound to tcie_core and sees only its ports.
`timescale 1ns/100ps
module tcie_core_sva (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels.
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Each taken request closes its channel, and every answer waits for its ready.
	a_aw_take_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address ready stayed high after a take");
	a_w_take_drop: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("write data ready stayed high after a take");
	a_b_bound: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[2:5] s_axi_bvalid)
		else $error("write response came too late");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response changed before it was taken");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response stayed after it was taken");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data did not follow the address");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data changed before it was taken");
	a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data stayed after it was taken");
endmodule

bind tcie_core tcie_core_sva chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== tb/test_tiny_core_instruction_execute.sv
// Self-checking bench that runs random instructions and compares with a model.
// Assumes the core, its package, the checker and the program store are compiled.
`timescale 1ns/100ps
module test_tiny_core_instruction_execute;
	localparam int LIMIT = 60000;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic rom_ld = 1'b0;
	logic [7:0] rom_a = 8'h00;
	logic [31:0] rom_d = 32'h00000000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, cy, kd;
	logic [31:0] rdata, rom_q, w, d;
	logic [7:0] g [32];
	logic [7:0] io [32];
	logic [7:0] fl;
	logic [15:0] pc, ret;
	logic [4:0] md;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;

	// Clock of 10 ns.
	always #5 aclk = ~aclk;

	tcie_core uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tcie_prog_rom rom (.aclk(aclk), .load(rom_ld), .addr(rom_a), .wdata(rom_d), .rdata(rom_q));

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Bus write: both channels offered together, response ready after a random pause.
	task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ta = ta || awready;
			tw = tw || wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		repeat ($urandom % 3) @(posedge aclk);
		bready <= 1'b1;
		do @(negedge aclk); while (!bvalid);
		chk("bresp", 32'(er), 32'(bresp));
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	// Bus read with a random pause before the data ready.
	task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] dv);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge aclk);
		rready <= 1'b1;
		do @(negedge aclk); while (!rvalid);
		dv = rdata;
		chk("rresp", 32'(er), 32'(rresp));
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Model of an eight-bit add or subtract with its six flags.
	function automatic void af(input logic [7:0] x, input logic [7:0] y, input logic ci,
		input logic sb, input logic st, input logic wb);
		logic [8:0] s;
		logic h, v;
		s = sb ? {1'b0, x} - y - ci : {1'b0, x} + y + ci;
		h = sb ? ({1'b0, x[3:0]} < y[3:0] + ci) : ({1'b0, x[3:0]} + y[3:0] + ci > 5'h0f);
		v = (sb ? x[7] != y[7] : x[7] == y[7]) && s[7] != x[7];
		fl[5:0] = {h, s[7] ^ v, v, s[7], s[7:0] == 8'h00 && (!st || fl[1]), s[8]};
		if (wb) g[md] = s[7:0];
	endfunction

	// Model of a logic result: zero and negative set, overflow cleared.
	function automatic void lf(input logic [7:0] x);
		g[md] = x;
		fl[3:1] = {1'b0, x[7], x == 8'h00};
	endfunction

	// Model of one instruction: registers, flags, program counter and cycles.
	task automatic step(input logic [31:0] iw);
		logic [7:0] a, b, k, r8;
		logic [15:0] p, r, n;
		logic [2:0] s;
		logic t, c, v, iob;
		md = iw[26:22];
		a = g[md];
		b = g[iw[21:17]];
		k = iw[15:8];
		s = iw[2:0];
		iob = k[5] ? 1'b0 : io[k[4:0]][s];
		p = {g[md | 5'h01], g[md & 5'h1e]};
		n = pc + 16'h0001;
		cy = 2'h1;
		kd = 2'h0;
		t = 1'b0;
		case (iw[31:27])
			tcie_pkg::OP_ADC: af(a, b, fl[0], 1'b0, 1'b0, 1'b1);
			tcie_pkg::OP_WADD, tcie_pkg::OP_WSUB: begin
				c = !iw[27];
				r = c ? p - k[5:0] : p + k[5:0];
				v = c ? p[15] & ~r[15] : ~p[15] & r[15];
				fl[4:0] = {r[15] ^ v, v, r[15], r == 16'h0000, c ? {10'h0, k[5:0]} > p : r < p};
				g[md | 5'h01] = r[15:8];
				g[md & 5'h1e] = r[7:0];
				cy = 2'h2;
			end
			tcie_pkg::OP_SUBC: af(a, b, fl[0], 1'b1, 1'b1, 1'b1);
			tcie_pkg::OP_SUBK: af(a, k, 1'b0, 1'b1, 1'b0, 1'b1);
			tcie_pkg::OP_ANDK: lf(a & k);
			tcie_pkg::OP_ORK, tcie_pkg::OP_SETM: lf(a | k);
			tcie_pkg::OP_CLRM: lf(a & (8'hff - k));
			tcie_pkg::OP_TEST: lf(a & a);
			tcie_pkg::OP_JPTR: {cy, n} = {2'h2, g[31], g[30]};
			tcie_pkg::OP_CPTR: begin
				ret = pc + 16'h0001;
				{cy, n} = {2'h3, g[31], g[30]};
			end
			tcie_pkg::OP_CSEQ: {kd, t} = {2'h1, a == b};
			tcie_pkg::OP_CMPK: af(a, k, 1'b0, 1'b1, 1'b0, 1'b0);
			tcie_pkg::OP_SRBC: {kd, t} = {2'h1, !a[s]};
			tcie_pkg::OP_SRBS: {kd, t} = {2'h1, a[s]};
			tcie_pkg::OP_SIBC: {kd, t} = {2'h1, !iob};
			tcie_pkg::OP_SIBS: {kd, t} = {2'h1, iob};
			tcie_pkg::OP_BFS: {kd, t} = {2'h2, fl[s]};
			tcie_pkg::OP_BSGE: {kd, t} = {2'h2, !(fl[2] ^ fl[3])};
			tcie_pkg::OP_BUGE: {kd, t} = {2'h2, !fl[0]};
			tcie_pkg::OP_BIE: {kd, t} = {2'h2, fl[7]};
			tcie_pkg::OP_BID: {kd, t} = {2'h2, !fl[7]};
			tcie_pkg::OP_SETIO, tcie_pkg::OP_CLRIO: begin
				if (!k[5]) io[k[4:0]][s] = iw[31:27] == tcie_pkg::OP_SETIO;
				cy = 2'h2;
			end
			tcie_pkg::OP_RORC: begin
				r8 = {fl[0], a[7:1]};
				fl[4:0] = {a[0], r8[7] ^ a[0], r8[7], r8 == 8'h00, a[0]};
				g[md] = r8;
			end
			tcie_pkg::OP_TSTORE: fl[6] = a[s];
			tcie_pkg::OP_TLOAD: g[md][s] = fl[6];
			tcie_pkg::OP_CLROV: fl[3] = 1'b0;
			tcie_pkg::OP_SETOV: fl[3] = 1'b1;
			default: ;
		endcase
		if (kd == 2'h1 && t) {cy, n} = iw[16] ? {2'h3, pc + 16'h3} : {2'h2, pc + 16'h2};
		if (kd == 2'h2 && t) {cy, n} = {2'h2, pc + {{9{k[6]}}, k[6:0]} + 16'h1};
		pc = n;
	endtask

	// Reset, load the program, seed the registers, then run and compare.
	initial begin
		void'($urandom(52268));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 256; i++) begin
			@(posedge aclk);
			rom_ld <= 1'b1;
			rom_a <= 8'(i);
			rom_d <= $urandom;
		end
		@(posedge aclk);
		rom_ld <= 1'b0;
		rd(tcie_pkg::OFS_PC, tcie_pkg::RESP_OKAY, d);
		chk("pc after reset", 32'h0, d);
		rd(tcie_pkg::OFS_FLAGS, tcie_pkg::RESP_OKAY, d);
		chk("flags after reset", 32'h0, d);
		wr(12'h020, 32'h5a, tcie_pkg::RESP_SLVERR);
		rd(12'h020, tcie_pkg::RESP_SLVERR, d);
		chk("unmapped read", 32'h0, d);
		wr(tcie_pkg::OFS_STATUS, 32'hffff, tcie_pkg::RESP_OKAY);
		for (int i = 0; i < 32; i++) begin
			g[i] = 8'($urandom);
			io[i] = 8'($urandom);
			wr(tcie_pkg::OFS_GPR + 12'(i * 4), {24'h0, g[i]}, tcie_pkg::RESP_OKAY);
			wr(tcie_pkg::OFS_IO + 12'(i * 4), {24'h0, io[i]}, tcie_pkg::RESP_OKAY);
		end
		pc = 16'($urandom);
		wr(tcie_pkg::OFS_PC, {16'h0, pc}, tcie_pkg::RESP_OKAY);
		ret = 16'h0;
		for (int i = 0; i < 320; i++) begin
			fl = 8'($urandom);
			wr(tcie_pkg::OFS_FLAGS, {24'h0, fl}, tcie_pkg::RESP_OKAY);
			rom_a <= pc[7:0];
			@(negedge aclk);
			w = {5'(i), rom_q[26:0]};
			step(w);
			wr(tcie_pkg::OFS_INSTR, w, tcie_pkg::RESP_OKAY);
			rd(tcie_pkg::OFS_INSTR, tcie_pkg::RESP_OKAY, d);
			chk("instr", w, d);
			d = 32'h1;
			for (int j = 0; j < 4 && d[0] !== 1'b0; j++) begin
				rd(tcie_pkg::OFS_STATUS, tcie_pkg::RESP_OKAY, d);
			end
			chk("status", {16'h0, fl, 5'h0, cy, 1'b0}, d & 32'h0000ff07);
			rd(tcie_pkg::OFS_PC, tcie_pkg::RESP_OKAY, d);
			chk("pc", {16'h0, pc}, d);
			rd(tcie_pkg::OFS_GPR + {5'h0, md, 2'h0}, tcie_pkg::RESP_OKAY, d);
			chk("dest", {24'h0, g[md]}, d);
			rd(tcie_pkg::OFS_GPR + {5'h0, md ^ 5'h01, 2'h0}, tcie_pkg::RESP_OKAY, d);
			chk("pair", {24'h0, g[md ^ 5'h01]}, d);
			rd(tcie_pkg::OFS_IO + {5'h0, w[12:8], 2'h0}, tcie_pkg::RESP_OKAY, d);
			chk("io", {24'h0, io[w[12:8]]}, d);
			rd(tcie_pkg::OFS_RET, tcie_pkg::RESP_OKAY, d);
			chk("ret", {16'h0, ret}, d);
		end
		end_sim();
	end
endmodule
